// file: hdl/instruction_dispatch_decode.sv
// Opcode latch, dispatch tables, class lookup, branch test and register destination flag.
`timescale 1ns/1ps

module instruction_dispatch_decode #(
  parameter logic [(2**dispatch_decode_pkg::OPCODE_TABLE_ADDR_W)*dispatch_decode_pkg::BYTE_W-1:0]
    OPCODE_TABLE = '0,
  parameter logic [(2**dispatch_decode_pkg::SPEC_TABLE_ADDR_W)*dispatch_decode_pkg::BYTE_W-1:0]
    SPEC_TABLE = '0,
  parameter logic [(2**dispatch_decode_pkg::CLASS_TABLE_ADDR_W)*dispatch_decode_pkg::CLASS_TABLE_DATA_W-1:0]
    CLASS_TABLE = '0
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_decode,
  input wire logic [dispatch_decode_pkg::WORD_W-1:0] i_control_store_word,
  input wire logic i_dispatch_jump_enable,
  input wire logic i_legacy_mode,
  input wire logic [dispatch_decode_pkg::BYTE_W-1:0] i_prefetch_byte,
  input wire logic i_interrupt_above_priority,
  input wire logic i_interrupt_dispatch_inhibit,
  input wire logic [dispatch_decode_pkg::FLAGS_W-1:0] i_processor_status_flags,
  output logic o_prefetch_unload_active,
  output logic o_latch_drives_bus,
  output logic [dispatch_decode_pkg::BYTE_W-1:0] o_opcode_latch,
  output logic o_next_address_valid,
  output logic [dispatch_decode_pkg::BYTE_W-1:0] o_next_address_low_bus,
  output logic [dispatch_decode_pkg::JUMP_HI_W-1:0] o_next_address_high,
  output logic [dispatch_decode_pkg::SIZE_W-1:0] o_operand_size_code,
  output logic [dispatch_decode_pkg::CLASS_W-1:0] o_flag_class_code,
  output logic o_condition_sample,
  output logic o_opcode_lsb_save,
  output logic o_branch_not_taken,
  output logic o_register_destination_flag
);
  import dispatch_decode_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Control store fields of the current decode.
  logic dispatch_select_bit;
  logic load_regdest_bit;
  logic byte_request_bit;
  logic [FUNC_W-1:0] decode_function_field;
  logic [JUMP_HI_W-1:0] jump_hi_field;

  assign dispatch_select_bit = i_control_store_word[CSW_DISPATCH_SELECT];
  assign load_regdest_bit = i_control_store_word[CSW_LOAD_REGDEST];
  assign byte_request_bit = i_control_store_word[CSW_BYTE_REQUEST];
  assign decode_function_field = i_control_store_word[CSW_FUNC_LSB +: FUNC_W];
  assign jump_hi_field = i_control_store_word[CSW_JUMP_HI_LSB +: JUMP_HI_W];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction byte bus.
  logic prefetch_unload_active;
  logic [BYTE_W-1:0] instruction_byte_bus;
  logic [BYTE_W-1:0] opcode_latch;

  // Legacy mode takes a byte on every decode, whatever the request bit says.
  assign prefetch_unload_active = i_decode & (byte_request_bit | i_legacy_mode);
  // The latch owns the bus whenever no byte is being taken from the buffer.
  assign instruction_byte_bus = prefetch_unload_active ? i_prefetch_byte : opcode_latch;

  logic class_decode;
  assign class_decode = prefetch_unload_active & dispatch_select_bit &
    ((decode_function_field == FUNC_LEGACY_CLASS) | (decode_function_field == FUNC_NATIVE_CLASS));

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      opcode_latch <= RESET_OPCODE;
    end else if (class_decode) begin
      opcode_latch <= instruction_byte_bus;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_prefetch_unload_active <= 1'b0;
      o_latch_drives_bus <= 1'b1;
    end else begin
      o_prefetch_unload_active <= prefetch_unload_active;
      o_latch_drives_bus <= ~prefetch_unload_active;
    end
  end

  assign o_opcode_latch = opcode_latch;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt dispatch override.
  // The inhibit only counts when it was raised in the cycle right before the
  // decode, so it is remembered for exactly one cycle.
  logic inhibit_armed;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      inhibit_armed <= 1'b0;
    end else begin
      inhibit_armed <= i_interrupt_dispatch_inhibit;
    end
  end

  logic force_interrupt;
  assign force_interrupt = (decode_function_field == FUNC_NATIVE_CLASS) &
    i_interrupt_above_priority & ~inhibit_armed;

  ////////////////////////////////////////////////////////////////////////////
  // Table addressing.
  logic [OPCODE_TABLE_ADDR_W-1:0] opcode_addr;
  logic [SPEC_TABLE_ADDR_W-1:0] spec_addr;
  logic [CLASS_TABLE_ADDR_W-1:0] class_addr;
  logic [BYTE_W-1:0] opcode_data;
  logic [BYTE_W-1:0] spec_data;
  logic [CLASS_TABLE_DATA_W-1:0] class_data;

  assign opcode_addr = {decode_function_field[1:0], instruction_byte_bus};
  assign spec_addr = {decode_function_field, instruction_byte_bus[SPEC_WORD_SEL_W-1:0]};
  assign class_addr = {i_legacy_mode, instruction_byte_bus};

  // Registered table reads cost one cycle but keep the table outputs clean
  // for the next address mux.
  lookup_table #(
    .ADDR_W(OPCODE_TABLE_ADDR_W),
    .DATA_W(BYTE_W),
    .CONTENTS(OPCODE_TABLE)
  ) u_opcode_table (
    .i_sys_clk(i_sys_clk),
    .i_rd_en(i_decode),
    .i_addr(opcode_addr),
    .o_data(opcode_data)
  );

  lookup_table #(
    .ADDR_W(SPEC_TABLE_ADDR_W),
    .DATA_W(BYTE_W),
    .CONTENTS(SPEC_TABLE)
  ) u_specifier_table (
    .i_sys_clk(i_sys_clk),
    .i_rd_en(i_decode),
    .i_addr(spec_addr),
    .o_data(spec_data)
  );

  lookup_table #(
    .ADDR_W(CLASS_TABLE_ADDR_W),
    .DATA_W(CLASS_TABLE_DATA_W),
    .CONTENTS(CLASS_TABLE)
  ) u_class_table (
    .i_sys_clk(i_sys_clk),
    .i_rd_en(i_decode),
    .i_addr(class_addr),
    .o_data(class_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Second stage: what travels with the table read.
  logic s1_jump;
  logic s1_use_opcode_table;
  logic s1_force_interrupt;
  logic s1_class_decode;
  logic [JUMP_HI_W-1:0] s1_jump_hi;
  logic [FLAGS_W-1:0] s1_flags;
  logic s1_opcode_lsb;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      s1_jump <= 1'b0;
      s1_use_opcode_table <= 1'b0;
      s1_force_interrupt <= 1'b0;
      s1_class_decode <= 1'b0;
      s1_jump_hi <= RESET_JUMP_HI;
      s1_flags <= '0;
      s1_opcode_lsb <= 1'b0;
    end else begin
      s1_jump <= i_decode & i_dispatch_jump_enable;
      // The override clears the opcode table select even when the word asked
      // for it; the interrupt vector then wins over both table paths.
      s1_use_opcode_table <= dispatch_select_bit & ~force_interrupt;
      s1_force_interrupt <= force_interrupt;
      s1_class_decode <= class_decode;
      s1_jump_hi <= jump_hi_field;
      // Flags are taken as they stand during the class decode itself.
      s1_flags <= i_processor_status_flags;
      s1_opcode_lsb <= instruction_byte_bus[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next microaddress.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_next_address_valid <= 1'b0;
      o_next_address_low_bus <= RESET_NEXT_ADDR;
      o_next_address_high <= RESET_JUMP_HI;
    end else begin
      o_next_address_valid <= s1_jump;
      if (s1_jump) begin
        o_next_address_high <= s1_jump_hi;
        if (s1_force_interrupt) begin
          o_next_address_low_bus <= INTERRUPT_VECTOR;
        end else if (s1_use_opcode_table) begin
          o_next_address_low_bus <= opcode_data;
        end else begin
          o_next_address_low_bus <= spec_data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Size, flag class and branch test.
  logic [SIZE_W-1:0] table_size;
  logic [CLASS_W-1:0] table_class;
  logic branch_condition;

  assign table_size = class_data[CLASS_SIZE_LSB +: SIZE_W];
  assign table_class = class_data[CLASS_FLAG_LSB +: CLASS_W];

  // Size bit 0 with the class code names the flag combination to test.
  always_comb begin
    branch_condition = 1'b0;
    case ({table_size[0], table_class})
      3'h0: branch_condition = s1_flags[FLAG_Z];
      3'h1: branch_condition = s1_flags[FLAG_C] | s1_flags[FLAG_Z];
      3'h2: branch_condition = s1_flags[FLAG_V];
      3'h3: branch_condition = s1_flags[FLAG_C];
      3'h4: branch_condition = s1_flags[FLAG_N] | s1_flags[FLAG_Z];
      3'h5: branch_condition = (s1_flags[FLAG_N] ^ s1_flags[FLAG_V]) | s1_flags[FLAG_Z];
      3'h6: branch_condition = s1_flags[FLAG_N];
      3'h7: branch_condition = s1_flags[FLAG_N] ^ s1_flags[FLAG_V];
      default: branch_condition = 1'b0;
    endcase
  end

  // The size code is passed through as read; code SIZE_UNUSED is not filtered.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_operand_size_code <= RESET_SIZE;
      o_flag_class_code <= RESET_CLASS;
    end else if (s1_class_decode) begin
      o_operand_size_code <= table_size;
      o_flag_class_code <= table_class;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_condition_sample <= 1'b0;
      o_opcode_lsb_save <= 1'b0;
      o_branch_not_taken <= 1'b0;
    end else if (s1_class_decode) begin
      o_condition_sample <= branch_condition;
      o_opcode_lsb_save <= s1_opcode_lsb;
      // The flag drops when the condition state matches opcode bit 0.
      o_branch_not_taken <= branch_condition ^ s1_opcode_lsb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register destination detection.
  logic specifier_gate_select;
  logic mode_detect_a;
  logic mode_detect_b;

  assign specifier_gate_select = i_legacy_mode;

  always_comb begin
    if (specifier_gate_select) begin
      mode_detect_a = instruction_byte_bus[5:4] == LEGACY_MODE_HI;
      mode_detect_b = instruction_byte_bus[3] == LEGACY_MODE_LO;
    end else begin
      mode_detect_a = instruction_byte_bus[7:6] == NATIVE_MODE_HI;
      mode_detect_b = instruction_byte_bus[5:4] == NATIVE_MODE_LO;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_register_destination_flag <= 1'b0;
    end else if (i_decode) begin
      o_register_destination_flag <= load_regdest_bit & mode_detect_a & mode_detect_b;
    end
  end

endmodule

// file: hdl/lookup_table.sv
// Constant lookup table with a registered read port.
`timescale 1ns/1ps

module lookup_table #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8,
  parameter logic [(2**ADDR_W)*DATA_W-1:0] CONTENTS = '0
) (
  input wire logic i_sys_clk,
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_addr,
  output logic [DATA_W-1:0] o_data
);

  // Word n sits at bits n*DATA_W upward of the flat contents vector.
  always_ff @(posedge i_sys_clk) begin
    if (i_rd_en) begin
      o_data <= CONTENTS[i_addr*DATA_W +: DATA_W];
    end
  end

endmodule

// file: pkg/dispatch_decode_pkg.sv
// Shared constants for the instruction dispatch and decode block.
package dispatch_decode_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int BYTE_W = 8;
  localparam int WORD_W = 18;
  localparam int FUNC_W = 3;
  localparam int JUMP_HI_W = 6;
  localparam int SIZE_W = 2;
  localparam int CLASS_W = 2;
  localparam int FLAGS_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Table geometry.
  localparam int OPCODE_TABLE_ADDR_W = 10;
  localparam int SPEC_TABLE_ADDR_W = 9;
  localparam int SPEC_WORD_SEL_W = 6;
  localparam int CLASS_TABLE_ADDR_W = 9;
  localparam int CLASS_TABLE_DATA_W = SIZE_W + CLASS_W;
  // Position of the fields inside one class table word.
  localparam int CLASS_SIZE_LSB = 0;
  localparam int CLASS_FLAG_LSB = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in the control store word.
  localparam int CSW_DISPATCH_SELECT = 4;
  localparam int CSW_LOAD_REGDEST = 5;
  localparam int CSW_BYTE_REQUEST = 8;
  localparam int CSW_FUNC_LSB = 9;
  localparam int CSW_JUMP_HI_LSB = 12;

  // Positions of the processor status flags on their port.
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings.
  localparam logic [FUNC_W-1:0] FUNC_LEGACY_CLASS = 3'h1;
  localparam logic [FUNC_W-1:0] FUNC_NATIVE_CLASS = 3'h3;
  localparam logic [BYTE_W-1:0] INTERRUPT_VECTOR = 8'hFF;

  localparam logic [SIZE_W-1:0] SIZE_BYTE = 2'h0;
  localparam logic [SIZE_W-1:0] SIZE_WORD = 2'h1;
  localparam logic [SIZE_W-1:0] SIZE_UNUSED = 2'h2;
  localparam logic [SIZE_W-1:0] SIZE_LONG = 2'h3;

  localparam logic [CLASS_W-1:0] FLAGS_ADD = 2'h0;
  localparam logic [CLASS_W-1:0] FLAGS_SUB = 2'h1;
  localparam logic [CLASS_W-1:0] FLAGS_CMP = 2'h2;
  localparam logic [CLASS_W-1:0] FLAGS_LOGIC = 2'h3;

  // Native register mode is address mode five in bits 7:4 of the byte.
  localparam logic [1:0] NATIVE_MODE_HI = 2'h1;
  localparam logic [1:0] NATIVE_MODE_LO = 2'h1;
  // Legacy destination register mode is zero in bits 5:3 of the byte.
  localparam logic [1:0] LEGACY_MODE_HI = 2'h0;
  localparam logic LEGACY_MODE_LO = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [BYTE_W-1:0] RESET_OPCODE = 8'h00;
  localparam logic [BYTE_W-1:0] RESET_NEXT_ADDR = 8'h00;
  localparam logic [JUMP_HI_W-1:0] RESET_JUMP_HI = 6'h00;
  localparam logic [SIZE_W-1:0] RESET_SIZE = 2'h0;
  localparam logic [CLASS_W-1:0] RESET_CLASS = 2'h0;

endpackage

// file: tb/dispatch_decode_props.sv
// Port checker for the instruction dispatch and decode block.
`timescale 1ns/1ps
module dispatch_decode_props
  import dispatch_decode_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_decode,
  input wire logic [WORD_W-1:0] i_control_store_word,
  input wire logic i_dispatch_jump_enable,
  input wire logic i_legacy_mode,
  input wire logic [BYTE_W-1:0] i_prefetch_byte,
  input wire logic i_interrupt_above_priority,
  input wire logic i_interrupt_dispatch_inhibit,
  input wire logic o_prefetch_unload_active,
  input wire logic o_latch_drives_bus,
  input wire logic [BYTE_W-1:0] o_opcode_latch,
  input wire logic o_next_address_valid,
  input wire logic [BYTE_W-1:0] o_next_address_low_bus,
  input wire logic [JUMP_HI_W-1:0] o_next_address_high,
  input wire logic o_condition_sample,
  input wire logic o_opcode_lsb_save,
  input wire logic o_branch_not_taken,
  input wire logic o_register_destination_flag
);
  logic [2:0] fn;
  logic unl;
  logic cls;
  logic jmp;
  assign fn = i_control_store_word[11:9];
  assign unl = i_control_store_word[8] | i_legacy_mode;
  assign cls = i_decode & unl & i_control_store_word[4] & (fn == 3'h1 || fn == 3'h3);
  assign jmp = i_decode & i_dispatch_jump_enable;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  //////////////////////////////////////////////////////////////////////////////
  a_unload_track: assert property (1'b1 |=> o_prefetch_unload_active == $past(i_decode && unl))
    else $error("unload flag does not follow the decode");
  a_bus_owner: assert property (o_latch_drives_bus != o_prefetch_unload_active)
    else $error("byte bus owner wrong");
  a_latch_load: assert property (cls |=> o_opcode_latch == $past(i_prefetch_byte))
    else $error("opcode latch not loaded");
  a_latch_hold: assert property (!cls |=> $stable(o_opcode_latch))
    else $error("opcode latch changed");
  a_jump_addr: assert property (
    jmp |-> ##2 o_next_address_valid && o_next_address_high == $past(i_control_store_word[17:12], 2))
    else $error("jump address missing");
  a_valid_cause: assert property (o_next_address_valid |-> $past(jmp, 2))
    else $error("address pulse without jump");
  a_irq_force: assert property (
    jmp && fn == 3'h3 && i_interrupt_above_priority && !$past(i_interrupt_dispatch_inhibit)
    |-> ##2 o_next_address_low_bus == INTERRUPT_VECTOR)
    else $error("interrupt vector not forced");
  a_lsb_save: assert property (cls |-> ##2 o_opcode_lsb_save == $past(i_prefetch_byte[0], 2))
    else $error("opcode bit zero not saved");
  a_branch_xor: assert property (o_branch_not_taken == (o_condition_sample ^ o_opcode_lsb_save))
    else $error("branch flag wrong");
  a_regdest_clear: assert property (i_decode && !i_control_store_word[5] |=> !o_register_destination_flag)
    else $error("destination flag not cleared");
  a_regdest_set: assert property (
    i_decode && i_control_store_word[5] && (i_legacy_mode ? i_prefetch_byte[5:3] == 3'h0
    : (i_control_store_word[8] && i_prefetch_byte[7:4] == 4'h5)) |=> o_register_destination_flag)
    else $error("destination flag not set");
  c_class: cover property (cls && i_dispatch_jump_enable);
  c_force: cover property (jmp && fn == 3'h3 && i_interrupt_above_priority);
  c_regdest: cover property (o_register_destination_flag);
endmodule
bind instruction_dispatch_decode dispatch_decode_props PROPS (.i_sys_clk, .i_srst, .i_decode, .i_control_store_word,
  .i_dispatch_jump_enable, .i_legacy_mode, .i_prefetch_byte, .i_interrupt_above_priority,
  .i_interrupt_dispatch_inhibit, .o_prefetch_unload_active, .o_latch_drives_bus, .o_opcode_latch,
  .o_next_address_valid, .o_next_address_low_bus, .o_next_address_high, .o_condition_sample,
  .o_opcode_lsb_save, .o_branch_not_taken, .o_register_destination_flag);

// file: tb/microsequencer_model.sv
// Microsequencer stand-in that issues decode microwords to the block.
`timescale 1ns/1ps
module microsequencer_model
  import dispatch_decode_pkg::*;
(
  input wire logic i_sys_clk,
  output logic o_decode = 1'b0,
  output logic [WORD_W-1:0] o_control_store_word = '0,
  output logic o_dispatch_jump_enable = 1'b0,
  output logic o_interrupt_dispatch_inhibit = 1'b0
);
  // A masked decode needs the inhibit raised by a miscellaneous microword just before it.
  task automatic issue(input logic [WORD_W-1:0] word, input logic jump, input logic mask);
    if (mask) idle(1'b1);
    @(posedge i_sys_clk);
    #1;
    o_decode = 1'b1;
    o_control_store_word = word;
    o_dispatch_jump_enable = jump;
    o_interrupt_dispatch_inhibit = 1'b0;
  endtask
  // Fields of a non-decode microword mean nothing here, so they keep changing.
  task automatic idle(input logic inh);
    @(posedge i_sys_clk);
    #1;
    o_decode = 1'b0;
    o_dispatch_jump_enable = 1'b0;
    o_interrupt_dispatch_inhibit = inh;
    o_control_store_word = ~o_control_store_word;
  endtask
endmodule

// file: tb/tb_instruction_dispatch_decode.sv
// Self-checking bench for the instruction dispatch and decode block.
`timescale 1ns/1ps
module tb_instruction_dispatch_decode;
  import dispatch_decode_pkg::*;
  typedef struct {
    logic [7:0] low;
    logic [5:0] high;
    logic [3:0] ce;
    logic cs;
    logic lsb;
    logic rd;
    logic rdv;
  } note_type;
  // Table word n holds n * mul + 5, so expectations follow from the same formula.
  function automatic logic [8191:0] mk(input int words, input int w, input int mul);
    logic [8191:0] t;
    t = '0;
    for (int n = 0; n < words; n++)
      for (int b = 0; b < w; b++) t[n * w + b] = 1'((n * mul + 5) >> b);
    return t;
  endfunction
  function automatic logic cond(input logic [2:0] s, input logic [3:0] f);
    logic [7:0] t;
    t = {f[FLAG_N] ^ f[FLAG_V], f[FLAG_N], (f[FLAG_N] ^ f[FLAG_V]) | f[FLAG_Z], f[FLAG_N] | f[FLAG_Z],
      f[FLAG_C], f[FLAG_V], f[FLAG_C] | f[FLAG_Z], f[FLAG_Z]};
    return t[s];
  endfunction
  localparam logic [8191:0] OPCODE_T = mk(1024, 8, 7);
  localparam logic [8191:0] SPEC_F = mk(512, 8, 13);
  localparam logic [8191:0] CLASS_F = mk(512, 4, 11);
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_decode;
  logic [WORD_W-1:0] i_control_store_word;
  logic i_dispatch_jump_enable;
  logic i_interrupt_dispatch_inhibit;
  logic i_legacy_mode = 1'b0;
  logic [7:0] i_prefetch_byte = 8'h00;
  logic i_interrupt_above_priority = 1'b0;
  logic [3:0] i_processor_status_flags = 4'h0;
  logic o_latch_drives_bus;
  logic o_next_address_valid;
  logic [7:0] o_next_address_low_bus;
  logic [5:0] o_next_address_high;
  logic [1:0] o_operand_size_code;
  logic [1:0] o_flag_class_code;
  logic o_condition_sample;
  logic o_opcode_lsb_save;
  logic o_branch_not_taken;
  logic o_register_destination_flag;
  int error_cnt = 0;
  int checks = 0;
  note_type notes[$];
  logic [7:0] e_latch;
  logic [3:0] e_ce;
  logic e_cs;
  logic e_lsb;
  always #4 i_sys_clk = ~i_sys_clk;
  microsequencer_model SEQ (.i_sys_clk(i_sys_clk), .o_decode(i_decode), .o_control_store_word(i_control_store_word),
    .o_dispatch_jump_enable(i_dispatch_jump_enable), .o_interrupt_dispatch_inhibit(i_interrupt_dispatch_inhibit));
  instruction_dispatch_decode #(.OPCODE_TABLE(OPCODE_T), .SPEC_TABLE(SPEC_F[4095:0]), .CLASS_TABLE(CLASS_F[2047:0])) DUT (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_decode(i_decode), .i_control_store_word(i_control_store_word),
    .i_dispatch_jump_enable(i_dispatch_jump_enable), .i_legacy_mode(i_legacy_mode), .i_prefetch_byte(i_prefetch_byte),
    .i_interrupt_above_priority(i_interrupt_above_priority),
    .i_interrupt_dispatch_inhibit(i_interrupt_dispatch_inhibit), .i_processor_status_flags(i_processor_status_flags),
    .o_prefetch_unload_active(), .o_latch_drives_bus(o_latch_drives_bus), .o_opcode_latch(),
    .o_next_address_valid(o_next_address_valid), .o_next_address_low_bus(o_next_address_low_bus),
    .o_next_address_high(o_next_address_high), .o_operand_size_code(o_operand_size_code),
    .o_flag_class_code(o_flag_class_code), .o_condition_sample(o_condition_sample),
    .o_opcode_lsb_save(o_opcode_lsb_save),
    .o_branch_not_taken(o_branch_not_taken), .o_register_destination_flag(o_register_destination_flag));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Kinds: 0 native class, 1 legacy class, 2 opcode dispatch, 3 native specifier, 4 legacy destination.
  task automatic run_op(input int kind);
    logic [WORD_W-1:0] w;
    logic [7:0] b;
    logic [7:0] bus;
    logic [2:0] fn;
    logic lg;
    logic jmp;
    logic msk;
    logic irq;
    note_type nt;
    w = WORD_W'($urandom);
    b = 8'($urandom);
    jmp = $urandom % 4 != 0;
    msk = $urandom % 4 == 0;
    irq = $urandom % 3 == 0;
    lg = kind == 1 || kind == 4;
    fn = kind == 0 ? 3'h3 : kind == 1 ? 3'h1 : kind == 2 ? 3'h2 : kind == 4 ? 3'h6 : w[11:9];
    w[11:9] = fn;
    w[8] = kind == 0 || kind == 3;
    w[5] = w[5] && kind > 2;
    w[4] = kind < 3;
    if (w[0] && kind == 3) b[7:4] = 4'h5;
    if (w[0] && kind == 4) b[5:3] = 3'h0;
    SEQ.issue(w, jmp, msk);
    i_legacy_mode = lg;
    i_prefetch_byte = b;
    i_interrupt_above_priority = irq;
    i_processor_status_flags = 4'($urandom);
    bus = w[8] || lg ? b : e_latch;
    if ((w[8] || lg) && w[4] && (fn == 3'h1 || fn == 3'h3)) begin
      e_latch = b;
      e_ce = 4'(bus * 11 + 5 + (lg ? 256 * 11 : 0));
      e_cs = cond({e_ce[0], e_ce[3:2]}, i_processor_status_flags);
      e_lsb = b[0];
    end
    nt.low = fn == 3'h3 && irq && !msk ? 8'hFF : w[4] ? 8'({fn[1:0], bus} * 7 + 5) : 8'({fn, bus[5:0]} * 13 + 5);
    nt.high = w[17:12];
    nt.ce = e_ce;
    nt.cs = e_cs;
    nt.lsb = e_lsb;
    nt.rd = w[5] && (lg ? bus[5:3] == 3'h0 : bus[7:4] == 4'h5);
    nt.rdv = $urandom % 2;
    if (jmp) notes.push_back(nt);
    if (nt.rdv) begin
      SEQ.idle(1'b0);
      i_prefetch_byte = ~b;
    end
  endtask
  always @(negedge i_sys_clk) begin
    note_type nt;
    if (o_next_address_valid === 1'b1) begin
      nt = notes.pop_front();
      check("next_address_low", o_next_address_low_bus, nt.low);
      check("next_address_high", o_next_address_high, nt.high);
      check("operand_size", o_operand_size_code, nt.ce[1:0]);
      check("flag_class", o_flag_class_code, nt.ce[3:2]);
      check("condition_sample", o_condition_sample, nt.cs);
      check("opcode_lsb_save", o_opcode_lsb_save, nt.lsb);
      check("branch_not_taken", o_branch_not_taken, nt.cs ^ nt.lsb);
      if (nt.rdv) check("register_destination", o_register_destination_flag, nt.rd);
    end
  end
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hABD8));
    repeat (16) @(posedge i_sys_clk);
    #1;
    i_srst = 1'b0;
    for (int r = 0; r < 2; r++) begin
      e_latch = RESET_OPCODE;
      e_ce = {RESET_CLASS, RESET_SIZE};
      e_cs = 1'b0;
      e_lsb = 1'b0;
      check("latch_drives_bus", o_latch_drives_bus, 1'b1);
      for (int i = 0; i < 200; i++) run_op($urandom % 5);
      repeat (3) SEQ.idle(1'b0);
      i_srst = 1'b1;
      repeat (2) @(posedge i_sys_clk);
      #1;
      i_srst = 1'b0;
    end
    check("notes_left", 16'(notes.size()), 16'h0000);
    report_and_stop();
  end
endmodule
